// ==== hdl/sps_defs.svh ====
`ifndef SPS_DEFS_SVH
`define SPS_DEFS_SVH

// strap level that selects the serial port functions
`define SPS_STRAP_SERIAL 1'b1
// level that a uart line shows while idle
`define SPS_UART_IDLE 1'b1
// level returned to a core input whose pin is given to the other function
`define SPS_INPUT_IDLE 1'b0
// pad output level while the pad is not driven
`define SPS_PAD_QUIET 1'b0
// output enable level of a pad that is not driven (enable is active low)
`define SPS_OE_OFF 1'b1
// output enable level of a pad that is driven
`define SPS_OE_ON 1'b0

`endif

// ==== hdl/sps_pkg.sv ====
package sps_pkg;

  // function set carried by the shared pins
  typedef enum logic {
    SPS_MODE_GPIO_UART,
    SPS_MODE_SERIAL
  } sps_mode_t;

  // progress of the strap capture around reset
  typedef enum logic [1:0] {
    SPS_ST_HOLD,
    SPS_ST_RELEASE,
    SPS_ST_RUN
  } sps_state_t;

endpackage

// ==== hdl/sps_strap_latch.sv ====
`timescale 1ns/1ps
`include "sps_defs.svh"

module sps_strap_latch (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_strap,
  output sps_pkg::sps_mode_t o_mode,
  output logic o_mode_valid,
  output logic o_strap_serial
);
  import sps_pkg::*;

  logic sample_r;
  sps_state_t state_r;
  sps_mode_t mode_r;

  // strap follows the pin only while reset is low; the last sample wins
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      sample_r <= i_strap;
    end
  end

  // hold while reset is low, one release cycle, then run for good
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_r <= SPS_ST_HOLD;
    end else begin
      unique case (state_r)
        SPS_ST_HOLD: state_r <= SPS_ST_RELEASE;
        SPS_ST_RELEASE: state_r <= SPS_ST_RUN;
        SPS_ST_RUN: state_r <= SPS_ST_RUN;
        default: state_r <= SPS_ST_HOLD;
      endcase
    end
  end

  // mode is loaded only at the first edge after reset rises
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      mode_r <= SPS_MODE_GPIO_UART;
    end else if (state_r == SPS_ST_HOLD) begin
      mode_r <= (sample_r == `SPS_STRAP_SERIAL) ? SPS_MODE_SERIAL : SPS_MODE_GPIO_UART;
    end
  end

  // no other load path: mode stays put until the next reset
  assign o_mode = mode_r;
  assign o_mode_valid = (state_r == SPS_ST_RUN);
  assign o_strap_serial = (sample_r == `SPS_STRAP_SERIAL);

endmodule // sps_strap_latch

// ==== hdl/sps_pad_cell.sv ====
`timescale 1ns/1ps
`include "sps_defs.svh"

module sps_pad_cell (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_live,
  input wire logic i_sel_alt,
  input wire logic i_park_drive,
  input wire logic i_park_value,
  input wire logic i_main_out_only,
  input wire logic i_main_out,
  input wire logic i_main_drive,
  input wire logic i_alt_out,
  input wire logic i_alt_drive,
  output logic o_pad_out,
  output logic o_pad_oe_n
);
  logic armed_r;
  logic req_drive;
  logic out_nxt;
  logic oe_n_nxt;
  logic out_r;
  logic oe_n_r;

  assign req_drive = i_sel_alt ? i_alt_drive : i_main_drive;

  // arm only after the core shows its own drive request low once;
  // a core that leaves reset late cannot then grab the pin early
  always_ff @(posedge i_clk) begin
    if (!i_rst_n || !i_live) begin
      armed_r <= 1'b0;
    end else if (!req_drive) begin
      armed_r <= 1'b1;
    end
  end

  // park value in reset and until live, then the selected function;
  // reset parks at once rather than one edge later through i_live
  always_comb begin
    out_nxt = `SPS_PAD_QUIET;
    oe_n_nxt = `SPS_OE_OFF;
    if (!i_rst_n || !i_live) begin
      out_nxt = i_park_value;
      oe_n_nxt = i_park_drive ? `SPS_OE_ON : `SPS_OE_OFF;
    end else if (!i_sel_alt && i_main_out_only) begin
      out_nxt = (armed_r && i_main_drive) ? i_main_out : i_park_value;
      oe_n_nxt = `SPS_OE_ON;
    end else if (armed_r && req_drive) begin
      out_nxt = i_sel_alt ? i_alt_out : i_main_out;
      oe_n_nxt = `SPS_OE_ON;
    end
  end

  // pad levels leave from flops
  always_ff @(posedge i_clk) begin
    out_r <= out_nxt;
    oe_n_r <= oe_n_nxt;
  end

  assign o_pad_out = out_r;
  assign o_pad_oe_n = oe_n_r;

endmodule // sps_pad_cell

// ==== hdl/sps_pin_select.sv ====
`timescale 1ns/1ps
`include "sps_defs.svh"

module sps_pin_select (
  input wire logic I_SYS_CLK,
  input wire logic I_RST_N,
  input wire logic I_STRAP_SELECT_PIN,
  // package pins
  input wire logic I_SHARED_PIN_A,
  output logic O_SHARED_PIN_A,
  output logic O_SHARED_PIN_A_OE_N,
  input wire logic I_SHARED_PIN_B,
  output logic O_SHARED_PIN_B,
  output logic O_SHARED_PIN_B_OE_N,
  input wire logic I_SHARED_PIN_C,
  output logic O_SHARED_PIN_C,
  output logic O_SHARED_PIN_C_OE_N,
  input wire logic I_SHARED_PIN_D,
  output logic O_SHARED_PIN_D,
  output logic O_SHARED_PIN_D_OE_N,
  input wire logic I_PORT2_SERIAL_IN,
  output logic O_PORT2_SERIAL_OUT,
  output logic O_PORT2_SERIAL_OUT_OE_N,
  // serial port core side
  input wire logic I_PORT2_TX_CLOCK_OUT,
  input wire logic I_PORT2_TX_CLOCK_DRIVE,
  output logic O_PORT2_TX_CLOCK_IN,
  input wire logic I_PORT2_RX_CLOCK_OUT,
  input wire logic I_PORT2_RX_CLOCK_DRIVE,
  output logic O_PORT2_RX_CLOCK_IN,
  input wire logic I_PORT2_TX_FRAME_SYNC_OUT,
  input wire logic I_PORT2_TX_FRAME_SYNC_DRIVE,
  output logic O_PORT2_TX_FRAME_SYNC_IN,
  input wire logic I_PORT2_RX_FRAME_SYNC_OUT,
  input wire logic I_PORT2_RX_FRAME_SYNC_DRIVE,
  output logic O_PORT2_RX_FRAME_SYNC_IN,
  input wire logic I_PORT2_SERIAL_OUT_DATA,
  input wire logic I_PORT2_SERIAL_OUT_DRIVE,
  output logic O_PORT2_SERIAL_IN_DATA,
  // uart core side
  input wire logic I_UART_TX,
  input wire logic I_UART_TX_ACTIVE,
  output logic O_UART_RX,
  // general io core side
  input wire logic I_GENERAL_IO_THREE_OUT,
  input wire logic I_GENERAL_IO_THREE_DRIVE,
  output logic O_GENERAL_IO_THREE_IN,
  input wire logic I_GENERAL_IO_FIVE_OUT,
  input wire logic I_GENERAL_IO_FIVE_DRIVE,
  output logic O_GENERAL_IO_FIVE_IN,
  // selection status
  output sps_pkg::sps_mode_t O_PIN_MODE,
  output logic O_PIN_MODE_VALID
);
  import sps_pkg::*;

  // pin map, strap low then strap high, and state out of reset:
  //   pin a: io three or transmit clock, input either way
  //   pin b: uart transmit driven high, or receive clock as input
  //   pin c: io five or transmit frame sync, input either way
  //   pin d: uart receive or receive frame sync, input either way
  //   serial out: undriven until the port enables it
  //   serial in: not shared, passed through in both modes
  // every driven function must first show its drive request low once
  // after the mode is valid; a core still in its own reset cannot
  // then fight a far-side driver on a freshly released pin
  // limitation: the strap is read as a synchronous level, so a strap that
  // moves in the last reset cycle is taken as sampled at that edge

  // latch outputs and the mode decode built on them
  sps_mode_t mode;
  logic mode_valid;
  logic strap_serial;
  logic serial_sel;
  logic uart_park;
  logic serial_live;
  logic uart_live;

  // serial data out path
  logic dx_armed_r;
  logic dx_out_r;
  logic dx_oe_n_r;
  logic dx_oe_n_nxt;

  // registered return paths towards the cores
  logic tx_clock_in_r;
  logic rx_clock_in_r;
  logic tx_fs_in_r;
  logic rx_fs_in_r;
  logic serial_in_r;
  logic uart_rx_r;
  logic io_three_in_r;
  logic io_five_in_r;

  // picks a pin's level for a function, or its idle level if not chosen
  function automatic logic route_in(input logic chosen, input logic pin_level,
                                    input logic idle_level);
    route_in = chosen ? pin_level : idle_level;
  endfunction

  // true once the latched mode is valid and is the one asked for;
  // before that no function owns any pin
  function automatic logic owns_pins(input logic valid, input sps_mode_t latched,
                                     input sps_mode_t wanted);
    owns_pins = valid && (latched == wanted);
  endfunction

  // strap capture and one-time mode latch;
  // the mode only moves in reset and at the first edge after reset rises
  sps_strap_latch u_strap (
    .i_clk (I_SYS_CLK),
    .i_rst_n (I_RST_N),
    .i_strap (I_STRAP_SELECT_PIN),
    .o_mode (mode),
    .o_mode_valid (mode_valid),
    .o_strap_serial (strap_serial)
  );

  // pad cells pick the alternate function in serial mode
  assign serial_sel = (mode == SPS_MODE_SERIAL);
  // during reset the uart line is parked high whenever the strap asks for it;
  // the live strap sample is used because the mode is not loaded yet
  assign uart_park = !strap_serial;
  // return paths open only for the function that owns the pins
  assign serial_live = owns_pins(mode_valid, mode, SPS_MODE_SERIAL);
  assign uart_live = owns_pins(mode_valid, mode, SPS_MODE_GPIO_UART);

  // pin a: io three or transmit clock, both undriven after reset
  // until the owning core arms the pad
  sps_pad_cell u_pad_a (
    .i_clk (I_SYS_CLK),
    .i_rst_n (I_RST_N),
    .i_live (mode_valid),
    .i_sel_alt (serial_sel),
    .i_park_drive (1'b0),
    .i_park_value (`SPS_PAD_QUIET),
    .i_main_out_only (1'b0),
    .i_main_out (I_GENERAL_IO_THREE_OUT),
    .i_main_drive (I_GENERAL_IO_THREE_DRIVE),
    .i_alt_out (I_PORT2_TX_CLOCK_OUT),
    .i_alt_drive (I_PORT2_TX_CLOCK_DRIVE),
    .o_pad_out (O_SHARED_PIN_A),
    .o_pad_oe_n (O_SHARED_PIN_A_OE_N)
  );

  // pin b: uart transmit (always driven) or receive clock;
  // the uart line is driven high from the second reset edge onward, one edge after the strap sample
  sps_pad_cell u_pad_b (
    .i_clk (I_SYS_CLK),
    .i_rst_n (I_RST_N),
    .i_live (mode_valid),
    .i_sel_alt (serial_sel),
    .i_park_drive (uart_park),
    .i_park_value (`SPS_UART_IDLE),
    .i_main_out_only (1'b1),
    .i_main_out (I_UART_TX),
    .i_main_drive (I_UART_TX_ACTIVE),
    .i_alt_out (I_PORT2_RX_CLOCK_OUT),
    .i_alt_drive (I_PORT2_RX_CLOCK_DRIVE),
    .o_pad_out (O_SHARED_PIN_B),
    .o_pad_oe_n (O_SHARED_PIN_B_OE_N)
  );

  // pin c: io five or transmit frame sync;
  // same arming as pin a, both undriven after reset
  sps_pad_cell u_pad_c (
    .i_clk (I_SYS_CLK),
    .i_rst_n (I_RST_N),
    .i_live (mode_valid),
    .i_sel_alt (serial_sel),
    .i_park_drive (1'b0),
    .i_park_value (`SPS_PAD_QUIET),
    .i_main_out_only (1'b0),
    .i_main_out (I_GENERAL_IO_FIVE_OUT),
    .i_main_drive (I_GENERAL_IO_FIVE_DRIVE),
    .i_alt_out (I_PORT2_TX_FRAME_SYNC_OUT),
    .i_alt_drive (I_PORT2_TX_FRAME_SYNC_DRIVE),
    .o_pad_out (O_SHARED_PIN_C),
    .o_pad_oe_n (O_SHARED_PIN_C_OE_N)
  );

  // pin d: uart receive never drives, so the main drive is tied off;
  // frame sync in serial mode is the only driver this pin can get
  sps_pad_cell u_pad_d (
    .i_clk (I_SYS_CLK),
    .i_rst_n (I_RST_N),
    .i_live (mode_valid),
    .i_sel_alt (serial_sel),
    .i_park_drive (1'b0),
    .i_park_value (`SPS_PAD_QUIET),
    .i_main_out_only (1'b0),
    .i_main_out (`SPS_PAD_QUIET),
    .i_main_drive (1'b0),
    .i_alt_out (I_PORT2_RX_FRAME_SYNC_OUT),
    .i_alt_drive (I_PORT2_RX_FRAME_SYNC_DRIVE),
    .o_pad_out (O_SHARED_PIN_D),
    .o_pad_oe_n (O_SHARED_PIN_D_OE_N)
  );

  // serial data out arms once the port shows its enable low after reset;
  // a port that leaves reset with its enable stuck high stays undriven
  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RST_N || !mode_valid) begin
      dx_armed_r <= 1'b0;
    end else if (!I_PORT2_SERIAL_OUT_DRIVE) begin
      dx_armed_r <= 1'b1;
    end
  end

  // high impedance in reset and until the port enables the driver;
  // reset is read directly so the pad lets go at the first reset edge
  always_comb begin
    dx_oe_n_nxt = `SPS_OE_OFF;
    if (I_RST_N && mode_valid && dx_armed_r && I_PORT2_SERIAL_OUT_DRIVE) begin
      dx_oe_n_nxt = `SPS_OE_ON;
    end
  end

  // data always follows the port one cycle late; only the enable is gated
  always_ff @(posedge I_SYS_CLK) begin
    dx_out_r <= I_PORT2_SERIAL_OUT_DATA;
  end

  // enable flop, so the pad never sees a glitch from the gating terms
  always_ff @(posedge I_SYS_CLK) begin
    dx_oe_n_r <= dx_oe_n_nxt;
  end

  assign O_PORT2_SERIAL_OUT = dx_out_r;
  assign O_PORT2_SERIAL_OUT_OE_N = dx_oe_n_r;

  // pin a towards the serial port; unselected lines rest at idle so the
  // core never sees edges from a pin it does not own
  always_ff @(posedge I_SYS_CLK) begin
    tx_clock_in_r <= route_in(serial_live, I_SHARED_PIN_A, `SPS_INPUT_IDLE);
  end

  // pin a towards general io three
  always_ff @(posedge I_SYS_CLK) begin
    io_three_in_r <= route_in(uart_live, I_SHARED_PIN_A, `SPS_INPUT_IDLE);
  end

  // pin b towards the serial port; in uart mode the pin is an output only
  always_ff @(posedge I_SYS_CLK) begin
    rx_clock_in_r <= route_in(serial_live, I_SHARED_PIN_B, `SPS_INPUT_IDLE);
  end

  // pin c towards the serial port
  always_ff @(posedge I_SYS_CLK) begin
    tx_fs_in_r <= route_in(serial_live, I_SHARED_PIN_C, `SPS_INPUT_IDLE);
  end

  // pin c towards general io five
  always_ff @(posedge I_SYS_CLK) begin
    io_five_in_r <= route_in(uart_live, I_SHARED_PIN_C, `SPS_INPUT_IDLE);
  end

  // pin d towards the serial port
  always_ff @(posedge I_SYS_CLK) begin
    rx_fs_in_r <= route_in(serial_live, I_SHARED_PIN_D, `SPS_INPUT_IDLE);
  end

  // pin d towards the uart; idles high so an unowned line looks like a stop bit
  always_ff @(posedge I_SYS_CLK) begin
    uart_rx_r <= route_in(uart_live, I_SHARED_PIN_D, `SPS_UART_IDLE);
  end

  // serial data in is not shared, so it passes in every mode
  always_ff @(posedge I_SYS_CLK) begin
    serial_in_r <= I_PORT2_SERIAL_IN;
  end

  // serial port returns
  assign O_PORT2_TX_CLOCK_IN = tx_clock_in_r;
  assign O_PORT2_RX_CLOCK_IN = rx_clock_in_r;
  assign O_PORT2_TX_FRAME_SYNC_IN = tx_fs_in_r;
  assign O_PORT2_RX_FRAME_SYNC_IN = rx_fs_in_r;
  assign O_PORT2_SERIAL_IN_DATA = serial_in_r;

  // uart and general io returns
  assign O_UART_RX = uart_rx_r;
  assign O_GENERAL_IO_THREE_IN = io_three_in_r;
  assign O_GENERAL_IO_FIVE_IN = io_five_in_r;

  // status straight from the latch; valid tells the cores
  // when the pin functions have settled
  assign O_PIN_MODE = mode;
  assign O_PIN_MODE_VALID = mode_valid;

endmodule // sps_pin_select

// ==== testbench/sps_far_pads.sv ====
`timescale 1ns/1ps

module sps_far_pads (
  input wire logic i_clk,
  input wire logic [3:0] i_dev_out,
  input wire logic [3:0] i_dev_oe_n,
  input wire logic [3:0] i_ext_en,
  input wire logic [3:0] i_ext_val,
  output logic [3:0] o_pin
);
  logic [3:0] float_r = 4'h5;

  // an undriven pad wanders, so a stale level never passes for a real one
  always @(posedge i_clk) begin
    float_r <= ~float_r;
  end

  // the chip wins, then the far driver, else the wandering level
  assign o_pin = (~i_dev_oe_n & i_dev_out) | (i_dev_oe_n & i_ext_en & i_ext_val)
    | (i_dev_oe_n & ~i_ext_en & float_r);
endmodule // sps_far_pads

// ==== testbench/sps_pin_select_props.sv ====
`timescale 1ns/1ps

module sps_pin_select_props (
  input wire logic I_SYS_CLK,
  input wire logic I_RST_N,
  input wire logic I_STRAP_SELECT_PIN,
  input wire logic I_SHARED_PIN_A,
  input wire logic I_SHARED_PIN_D,
  input wire logic O_SHARED_PIN_B,
  input wire logic O_SHARED_PIN_A_OE_N,
  input wire logic O_SHARED_PIN_B_OE_N,
  input wire logic O_SHARED_PIN_C_OE_N,
  input wire logic O_SHARED_PIN_D_OE_N,
  input wire logic O_PORT2_SERIAL_OUT_OE_N,
  input wire logic I_PORT2_SERIAL_OUT_DRIVE,
  input wire logic I_UART_TX,
  input wire logic I_UART_TX_ACTIVE,
  input wire logic O_PORT2_TX_CLOCK_IN,
  input wire logic O_PORT2_RX_FRAME_SYNC_IN,
  input wire logic O_UART_RX,
  input wire logic O_GENERAL_IO_THREE_IN,
  input sps_pkg::sps_mode_t O_PIN_MODE,
  input wire logic O_PIN_MODE_VALID
);
  import sps_pkg::*;
  logic ser_mode;

  // one clock domain, reset gates all but the parking checks
  default clocking @(posedge I_SYS_CLK);
  endclocking
  default disable iff (!I_RST_N);
  assign ser_mode = (O_PIN_MODE == SPS_MODE_SERIAL);

  // release edge, and the uart line handed over after one idle edge
  sequence s_release;
    $rose(I_RST_N);
  endsequence
  sequence s_uart_arm;
    O_PIN_MODE_VALID && !ser_mode && !I_UART_TX_ACTIVE ##1 I_UART_TX_ACTIVE;
  endsequence

  a_mode_latch:
    assert property (s_release |=> O_PIN_MODE == $past(I_STRAP_SELECT_PIN, 2))
    else $error("mode not taken from strap");
  a_valid_late:
    assert property (s_release |-> !O_PIN_MODE_VALID ##1 !O_PIN_MODE_VALID ##1 O_PIN_MODE_VALID)
    else $error("mode valid at wrong edge");
  a_mode_steady:
    assert property (O_PIN_MODE_VALID |=> $stable(O_PIN_MODE))
    else $error("mode moved without reset");
  a_uart_parked:
    assert property (disable iff (1'b0) (!I_RST_N && !I_STRAP_SELECT_PIN) [*3]
      |-> O_SHARED_PIN_B && !O_SHARED_PIN_B_OE_N)
    else $error("uart pin not high in reset");
  a_serout_quiet:
    assert property (disable iff (1'b0) (!I_RST_N || !I_PORT2_SERIAL_OUT_DRIVE) [*2]
      |-> O_PORT2_SERIAL_OUT_OE_N)
    else $error("serial out driven");
  a_start_input:
    assert property (s_release
      |-> (O_SHARED_PIN_A_OE_N && O_SHARED_PIN_C_OE_N && O_SHARED_PIN_D_OE_N) [*3])
    else $error("pad driven after release");
  a_rxclk_input:
    assert property (s_release ##1 ser_mode |-> O_SHARED_PIN_B_OE_N [*2])
    else $error("receive clock pad driven");
  a_route_a:
    assert property (O_PIN_MODE_VALID |=> ser_mode
      ? O_PORT2_TX_CLOCK_IN == $past(I_SHARED_PIN_A) && !O_GENERAL_IO_THREE_IN
      : O_GENERAL_IO_THREE_IN == $past(I_SHARED_PIN_A) && !O_PORT2_TX_CLOCK_IN)
    else $error("pin a routed wrong");
  a_route_d:
    assert property (O_PIN_MODE_VALID |=> ser_mode
      ? O_PORT2_RX_FRAME_SYNC_IN == $past(I_SHARED_PIN_D) && O_UART_RX
      : O_UART_RX == $past(I_SHARED_PIN_D) && !O_PORT2_RX_FRAME_SYNC_IN && O_SHARED_PIN_D_OE_N)
    else $error("pin d routed wrong");
  a_uart_drive:
    assert property (s_uart_arm |=> O_SHARED_PIN_B == $past(I_UART_TX) && !O_SHARED_PIN_B_OE_N)
    else $error("uart pin not following uart");
endmodule // sps_pin_select_props

bind sps_pin_select sps_pin_select_props props_u (.*);

// ==== testbench/testbench.sv ====
`timescale 1ns/1ps

module testbench;
  import sps_pkg::*;
  logic I_SYS_CLK, I_RST_N, I_STRAP_SELECT_PIN, I_PORT2_SERIAL_IN, O_PIN_MODE_VALID;
  logic I_SHARED_PIN_A, I_SHARED_PIN_B, I_SHARED_PIN_C, I_SHARED_PIN_D;
  logic O_SHARED_PIN_A, O_SHARED_PIN_B, O_SHARED_PIN_C, O_SHARED_PIN_D, O_PORT2_SERIAL_OUT;
  logic O_SHARED_PIN_A_OE_N, O_SHARED_PIN_B_OE_N, O_SHARED_PIN_C_OE_N, O_SHARED_PIN_D_OE_N;
  logic O_PORT2_SERIAL_OUT_OE_N, O_PORT2_SERIAL_IN_DATA, O_UART_RX, I_UART_TX, I_UART_TX_ACTIVE;
  logic I_PORT2_TX_CLOCK_OUT, I_PORT2_TX_CLOCK_DRIVE, O_PORT2_TX_CLOCK_IN;
  logic I_PORT2_RX_CLOCK_OUT, I_PORT2_RX_CLOCK_DRIVE, O_PORT2_RX_CLOCK_IN;
  logic I_PORT2_TX_FRAME_SYNC_OUT, I_PORT2_TX_FRAME_SYNC_DRIVE, O_PORT2_TX_FRAME_SYNC_IN;
  logic I_PORT2_RX_FRAME_SYNC_OUT, I_PORT2_RX_FRAME_SYNC_DRIVE, O_PORT2_RX_FRAME_SYNC_IN;
  logic I_PORT2_SERIAL_OUT_DATA, I_PORT2_SERIAL_OUT_DRIVE;
  logic I_GENERAL_IO_THREE_OUT, I_GENERAL_IO_THREE_DRIVE, O_GENERAL_IO_THREE_IN;
  logic I_GENERAL_IO_FIVE_OUT, I_GENERAL_IO_FIVE_DRIVE, O_GENERAL_IO_FIVE_IN;
  sps_mode_t O_PIN_MODE;
  logic [7:0] drv = 8'hff;
  logic [7:0] dat = 8'h4d;
  logic [3:0] ext_en = 4'h0;
  logic [3:0] ext_val = 4'h0;
  logic [3:0] pins;
  logic [4:0] oe_w;
  logic [3:0] pad_w;
  logic [7:0] ret_w;
  int err_count = 0;
  int comparisons = 0;
  int cycles = 0;

  // core requests move together so every path gets armed at once
  assign {I_UART_TX_ACTIVE, I_PORT2_TX_CLOCK_DRIVE, I_PORT2_RX_CLOCK_DRIVE,
    I_PORT2_TX_FRAME_SYNC_DRIVE, I_PORT2_RX_FRAME_SYNC_DRIVE, I_PORT2_SERIAL_OUT_DRIVE,
    I_GENERAL_IO_THREE_DRIVE, I_GENERAL_IO_FIVE_DRIVE} = drv;
  assign {I_UART_TX, I_PORT2_TX_CLOCK_OUT, I_PORT2_RX_CLOCK_OUT, I_PORT2_TX_FRAME_SYNC_OUT,
    I_PORT2_RX_FRAME_SYNC_OUT, I_PORT2_SERIAL_OUT_DATA, I_GENERAL_IO_THREE_OUT,
    I_GENERAL_IO_FIVE_OUT} = dat;
  assign {I_SHARED_PIN_A, I_SHARED_PIN_B, I_SHARED_PIN_C, I_SHARED_PIN_D} = pins;
  assign oe_w = {O_SHARED_PIN_A_OE_N, O_SHARED_PIN_B_OE_N, O_SHARED_PIN_C_OE_N,
    O_SHARED_PIN_D_OE_N, O_PORT2_SERIAL_OUT_OE_N};
  assign pad_w = {O_SHARED_PIN_A, O_SHARED_PIN_B, O_SHARED_PIN_C, O_PORT2_SERIAL_OUT};
  assign ret_w = {O_PORT2_TX_CLOCK_IN, O_PORT2_RX_CLOCK_IN, O_PORT2_TX_FRAME_SYNC_IN,
    O_PORT2_RX_FRAME_SYNC_IN, O_GENERAL_IO_THREE_IN, O_GENERAL_IO_FIVE_IN, O_UART_RX,
    O_PORT2_SERIAL_IN_DATA};

  sps_pin_select dut_u (.*);
  sps_far_pads far_u (
    .i_clk(I_SYS_CLK),
    .i_dev_out({O_SHARED_PIN_A, O_SHARED_PIN_B, O_SHARED_PIN_C, O_SHARED_PIN_D}),
    .i_dev_oe_n(oe_w[4:1]),
    .i_ext_en(ext_en),
    .i_ext_val(ext_val),
    .o_pin(pins)
  );

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // inputs land 1 ns after the edge, outputs are read there too
  task automatic tick(input int n);
    repeat (n) @(posedge I_SYS_CLK);
    #1;
  endtask

  // strap flips halfway through reset, so only the last level may count
  task automatic start(input logic s);
    int n;
    n = 0;
    I_RST_N = 1'b0;
    drv = 8'hff;
    ext_en = 4'h0;
    I_STRAP_SELECT_PIN = ~s;
    tick(8);
    I_STRAP_SELECT_PIN = s;
    tick(8);
    chk("reset_oe_n", oe_w, s ? 8'h1f : 8'h17);
    chk("reset_uart", O_SHARED_PIN_B | s, 8'h01);
    I_RST_N = 1'b1;
    while (O_PIN_MODE_VALID !== 1'b1 && n < 8) begin
      tick(1);
      n++;
    end
    chk("valid_lag", 8'(n), 8'h02);
    chk("mode", O_PIN_MODE, s);
    tick(2);
    chk("start_oe_n", oe_w, s ? 8'h1f : 8'h17);
    chk("start_uart", O_SHARED_PIN_B | s, 8'h01);
  endtask

  // far side drives every pad, neighbouring pins at opposite levels to catch swaps
  task automatic returns(input logic s);
    logic [3:0] p;
    for (int v = 0; v < 2; v++) begin
      p = v[0] ? 4'ha : 4'h5;
      ext_en = 4'hf;
      ext_val = p;
      I_PORT2_SERIAL_IN = v[0];
      tick(1);
      chk("returns", ret_w, s ? {p, 3'b001, v[0]} : {4'h0, p[3], p[1], p[0], v[0]});
    end
    ext_en = 4'h0;
  endtask

  task automatic arm(input logic s);
    drv = 8'h00;
    tick(1);
    drv = 8'hff;
    tick(1);
    chk("arm_oe_n", oe_w, s ? 8'h00 : 8'h02);
    chk("arm_pads", pad_w, s ? {dat[6], dat[5], dat[4], dat[2]} : {dat[1], dat[7], dat[0], dat[2]});
    if (s) chk("arm_pad_d", O_SHARED_PIN_D, dat[3]);
  endtask

  task automatic hold(input logic s);
    repeat (4) begin
      I_STRAP_SELECT_PIN = ~I_STRAP_SELECT_PIN;
      tick(1);
      chk("mode_hold", O_PIN_MODE, s);
    end
    drv = 8'h00;
    tick(1);
    chk("drop_oe_n", oe_w, s ? 8'h1f : 8'h17);
  endtask

  task automatic conclude();
    if (err_count == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    I_SYS_CLK = 1'b0;
    forever #5 I_SYS_CLK = ~I_SYS_CLK;
  end

  // the second pass resets mid-run with every pad still armed but undriven
  initial begin
    I_PORT2_SERIAL_IN = 1'b0;
    for (int m = 1; m >= 0; m--) begin
      start(m[0]);
      returns(m[0]);
      arm(m[0]);
      hold(m[0]);
    end
    conclude();
  end

  // the run needs about sixty cycles, so this only trips on a hang
  always @(posedge I_SYS_CLK) begin
    cycles++;
    if (cycles == 2000) begin
      err_count++;
      conclude();
    end
  end
endmodule // testbench
